// ===== hw/tcc_capture_compare.sv
// capture/compare unit of an 8/16-bit timer with 16-bit byte access over APB
//
// Behaviour
// - qualifying edge copies counter into capture register
// - capture flag set same cycle as copy
// - compare A holds capture; B high in 16-bit
// - 8-bit capture keeps B compare; 16-bit none
// - capture flag irq; clears on service or write-one
// - trigger from pin, or comparator when selected
// - pin and comparator sampled like count pin
// - edge select zero falling, one rising
// - filter needs four equal samples to change
// - filter adds four system clocks of delay
// - port-driven capture pin also triggers capture
// - each capture overwrites the capture register
// - equality sets compare flag next timer tick
// - 8-bit sets A or B; 16-bit only A
// - compare flags irq; clear on service or one
// - counter write blocks match next timer tick
// - width select makes registers 16-bit byte pairs
// - one shared temporary high byte, low triggers
// - low write loads temp high and low together
// - low read latches high into temporary
// - compare reads direct; 16-bit capture via temp
//
// The address map and the APB slave port are this design's own decisions.
module tcc_capture_compare (
    input wire logic clk_sys, // system clock, 25 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic capturePin, // capture pin, asynchronous
    input wire logic comparatorOut, // comparator output, asynchronous
    input wire logic timerTick, // timer tick from prescaler, same domain
    output logic captureIrq, // capture interrupt request
    output logic compareIrqA, // compare a interrupt request
    output logic compareIrqB // compare b interrupt request
);
    import tcc_pkg::*;

    // ==========================================================
    // register state
    // ==========================================================
    logic [7:0] ctrlA_r, ctrlA_nxt;
    logic [7:0] ctrlB_r, ctrlB_nxt;
    logic [15:0] countValue_r, countValue_nxt;
    logic [7:0] cmpA_r, cmpA_nxt;
    logic [7:0] cmpB_r, cmpB_nxt;
    // one temporary high byte shared by every 16-bit register
    logic [7:0] tempHigh_r, tempHigh_nxt;
    logic [TCC_NFLAG-1:0] flags_r, flags_nxt;
    logic [TCC_NFLAG-1:0] irqEn_r, irqEn_nxt;
    // a counter write waits here for the next timer tick to spend it
    logic blockMatch_r, blockMatch_nxt;
    // matches taken at one tick, raised as flags at the next
    logic [TCC_NFLAG-1:0] matchPend_r, matchPend_nxt;
    // next values of the registered apb answer
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt;

    // ==========================================================
    // input front end
    // ==========================================================
    logic [1:0] pinSync_r, acoSync_r;
    logic [TCC_FILT_SAMPLES-2:0] filtHist_r; // the three previous samples
    logic filtOut_r, filtOut_nxt;
    logic edgeLast_r;
    logic srcSel, filtIn, edgeIn, captureEvent;
    logic [TCC_FILT_SAMPLES-2:0] filtHist_nxt;
    logic [TCC_FILT_SAMPLES-1:0] filtWin; // newest sample and the history

    // two-stage synchronisers, same as the count pin path
    // nothing but the second stage reads the first, so a metastable
    // first stage never reaches the filter or the edge detector
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pinSync_r <= 2'h0;
            acoSync_r <= 2'h0;
        end else begin
            pinSync_r <= {pinSync_r[0], capturePin};
            acoSync_r <= {acoSync_r[0], comparatorOut};
        end
    end

    // source mux, filter and edge detector
    // switching the source or the filter can itself look like an edge,
    // so software clears the capture flag after such a change
    always_comb begin
        srcSel = ctrlA_r[TCC_CA_ACSEL];
        filtIn = srcSel ? acoSync_r[1] : pinSync_r[1];
        // the newest sample joins the three stored ones, so four equal
        // samples move the output with four clocks of extra delay
        filtWin = {filtHist_r, filtIn};
        filtHist_nxt = filtWin[TCC_FILT_SAMPLES-2:0];
        filtOut_nxt = filtOut_r;
        if (&filtWin) begin
            filtOut_nxt = 1'b1;
        end else if (~|filtWin) begin
            filtOut_nxt = 1'b0;
        end
        edgeIn = ctrlA_r[TCC_CA_FILT] ? filtOut_r : filtIn;
        // rising when edge select set, falling otherwise
        captureEvent = ctrlA_r[TCC_CA_CAPEN] &&
            (ctrlA_r[TCC_CA_EDGE] ? (edgeIn && !edgeLast_r)
                                  : (!edgeIn && edgeLast_r));
    end

    // filter history, filter output and edge memory
    // the edge memory follows its input even while capture is off, so
    // turning capture on finds no stale edge waiting
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            filtHist_r <= '0;
            filtOut_r <= 1'b0;
            edgeLast_r <= 1'b0;
        end else begin
            filtHist_r <= filtHist_nxt;
            filtOut_r <= filtOut_nxt;
            edgeLast_r <= edgeIn;
        end
    end

    // ==========================================================
    // bus decode
    // ==========================================================
    // decoded transfer, mode and match terms
    logic acc, wrAcc, rdAcc, mapped, wide, capMode, cap16;
    logic [7:0] wb;
    logic [15:0] cmp16;
    logic matchA, matchB, tickEn;

    // transfer qualifiers, mode decode and the match comparators
    always_comb begin
        acc = psel && penable && pready;
        wrAcc = acc && pwrite;
        rdAcc = acc && !pwrite;
        wb = pwdata[7:0];
        mapped = (paddr == TCC_ADDR_CTRL_A) || (paddr == TCC_ADDR_CTRL_B) ||
                 (paddr == TCC_ADDR_CNT_LO) || (paddr == TCC_ADDR_CNT_HI) ||
                 (paddr == TCC_ADDR_CMP_A) || (paddr == TCC_ADDR_CMP_B) ||
                 (paddr == TCC_ADDR_FLAGS) || (paddr == TCC_ADDR_IRQEN) ||
                 (paddr == TCC_ADDR_SVC);
        wide = ctrlA_r[TCC_CA_WIDTH];
        capMode = ctrlA_r[TCC_CA_CAPEN];
        cap16 = capMode && wide;
        cmp16 = {cmpB_r, cmpA_r};
        tickEn = timerTick && ctrlB_r[TCC_CB_RUN];
        // compare comparators, 16-bit uses one combined unit
        matchA = wide ? (countValue_r == cmp16)
                      : (countValue_r[7:0] == cmpA_r);
        matchB = !wide && (countValue_r[7:0] == cmpB_r);
    end

    // ==========================================================
    // next-state logic for registers, counter and flags
    // ==========================================================
    // every register except pready and pslverr holds unless an event or a cpu transfer moves it;
    // later assignments below win, so the order sets the priorities
    always_comb begin
        ctrlA_nxt = ctrlA_r;
        ctrlB_nxt = ctrlB_r;
        countValue_nxt = countValue_r;
        cmpA_nxt = cmpA_r;
        cmpB_nxt = cmpB_r;
        tempHigh_nxt = tempHigh_r;
        flags_nxt = flags_r;
        irqEn_nxt = irqEn_r;
        blockMatch_nxt = blockMatch_r;
        matchPend_nxt = matchPend_r;
        prdata_nxt = prdata;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;

        // simple counter on the timer tick; it wraps at its width and, in
        // 8-bit clear-on-match mode, restarts from zero on a match with A
        if (tickEn) begin
            countValue_nxt = wide ? countValue_r + 16'h0001
                                  : {8'h00, countValue_r[7:0] + 8'h01};
            if (!wide && !capMode && ctrlA_r[TCC_CA_WGM] && matchA) begin
                countValue_nxt = 16'h0000;
            end
        end

        // zero-wait-state apb answer: the answer is registered from the
        // setup cycle, so every access phase lasts exactly one clock;
        // an unmapped place answers with an error and reads zero
        if (psel && !penable) begin
            pready_nxt = 1'b1;
            pslverr_nxt = !mapped;
            prdata_nxt = 32'h0000_0000;
            case (paddr)
                TCC_ADDR_CTRL_A: prdata_nxt[7:0] = ctrlA_r & TCC_CA_MASK;
                TCC_ADDR_CTRL_B: prdata_nxt[7:0] = ctrlB_r;
                TCC_ADDR_CNT_LO: prdata_nxt[7:0] = countValue_r[7:0];
                TCC_ADDR_CNT_HI: prdata_nxt[7:0] =
                    wide ? tempHigh_r : countValue_r[15:8];
                TCC_ADDR_CMP_A: prdata_nxt[7:0] = cmpA_r;
                TCC_ADDR_CMP_B: prdata_nxt[7:0] =
                    cap16 ? tempHigh_r : cmpB_r;
                TCC_ADDR_FLAGS: prdata_nxt[TCC_NFLAG-1:0] = flags_r;
                TCC_ADDR_IRQEN: prdata_nxt[TCC_NFLAG-1:0] = irqEn_r;
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end

        // low-byte reads latch the high byte
        // the temporary byte is shared by every 16-bit register, so a
        // handler touching any of them between two halves spoils the pair
        if (rdAcc && wide && paddr == TCC_ADDR_CNT_LO) begin
            tempHigh_nxt = countValue_r[15:8];
        end
        if (rdAcc && cap16 && paddr == TCC_ADDR_CMP_A) begin
            tempHigh_nxt = cmpB_r;
        end

        // register writes; a low-byte counter write overrides a count on the same
        // clock, and write-one clears come before the hardware sets below
        // so that a set in the same cycle is never lost
        if (wrAcc) begin
            case (paddr)
                TCC_ADDR_CTRL_A: ctrlA_nxt = wb & TCC_CA_MASK;
                TCC_ADDR_CTRL_B: ctrlB_nxt = wb;
                TCC_ADDR_CNT_HI: begin
                    if (wide) begin
                        tempHigh_nxt = wb;
                    end else begin
                        countValue_nxt[15:8] = wb;
                    end
                    blockMatch_nxt = 1'b1;
                end
                TCC_ADDR_CNT_LO: begin
                    countValue_nxt = wide ? {tempHigh_r, wb}
                                          : {countValue_r[15:8], wb};
                    blockMatch_nxt = 1'b1;
                end
                TCC_ADDR_CMP_B: begin
                    if (wide) begin
                        tempHigh_nxt = wb;
                    end else begin
                        cmpB_nxt = wb;
                    end
                end
                TCC_ADDR_CMP_A: begin
                    cmpA_nxt = wb;
                    if (wide) begin
                        cmpB_nxt = tempHigh_r;
                    end
                end
                TCC_ADDR_FLAGS: flags_nxt = flags_r & ~wb[TCC_NFLAG-1:0];
                TCC_ADDR_IRQEN: irqEn_nxt = wb[TCC_NFLAG-1:0];
                // serviced interrupt clears its flag
                TCC_ADDR_SVC: flags_nxt = flags_r & ~wb[TCC_NFLAG-1:0];
                default: ;
            endcase
        end

        // a timer tick consumes a pending block and sets matched flags
        // a match seen at one tick raises its flag at the next tick; a
        // counter write since the last tick keeps that match from counting
        if (tickEn) begin
            if (matchPend_r[TCC_FL_CMPA]) begin
                flags_nxt[TCC_FL_CMPA] = 1'b1;
            end
            if (matchPend_r[TCC_FL_CMPB]) begin
                flags_nxt[TCC_FL_CMPB] = 1'b1;
            end
            matchPend_nxt = '0;
            if (!blockMatch_r && !cap16) begin
                matchPend_nxt[TCC_FL_CMPA] = matchA && !capMode;
                matchPend_nxt[TCC_FL_CMPB] = matchB;
            end
            if (!(wrAcc && (paddr == TCC_ADDR_CNT_LO ||
                            paddr == TCC_ADDR_CNT_HI))) begin
                blockMatch_nxt = 1'b0;
            end
        end

        // capture copies counter and sets flag together
        // a new event overwrites the time-stamp whether it was read or not
        if (captureEvent) begin
            cmpA_nxt = countValue_r[7:0];
            if (wide) begin
                cmpB_nxt = countValue_r[15:8];
            end
            flags_nxt[TCC_FL_CAP] = 1'b1;
        end
    end

    // ==========================================================
    // interrupt requests
    // ==========================================================
    logic [TCC_NFLAG-1:0] irqReq_nxt;

    // a request stands while its flag and its enable are both set
    always_comb begin
        irqReq_nxt = flags_nxt & irqEn_nxt;
    end

    // register the bus, counter and flag state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrlA_r <= TCC_RST_BYTE;
            ctrlB_r <= TCC_RST_BYTE;
            countValue_r <= 16'h0000;
            cmpA_r <= TCC_RST_BYTE;
            cmpB_r <= TCC_RST_BYTE;
            tempHigh_r <= TCC_RST_BYTE;
            flags_r <= '0;
            irqEn_r <= '0;
            blockMatch_r <= 1'b0;
            matchPend_r <= '0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            captureIrq <= 1'b0;
            compareIrqA <= 1'b0;
            compareIrqB <= 1'b0;
        end else begin
            ctrlA_r <= ctrlA_nxt;
            ctrlB_r <= ctrlB_nxt;
            countValue_r <= countValue_nxt;
            cmpA_r <= cmpA_nxt;
            cmpB_r <= cmpB_nxt;
            tempHigh_r <= tempHigh_nxt;
            flags_r <= flags_nxt;
            irqEn_r <= irqEn_nxt;
            blockMatch_r <= blockMatch_nxt;
            matchPend_r <= matchPend_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            // interrupt requests gated by enables
            captureIrq <= irqReq_nxt[TCC_FL_CAP];
            compareIrqA <= irqReq_nxt[TCC_FL_CMPA];
            compareIrqB <= irqReq_nxt[TCC_FL_CMPB];
        end
    end
endmodule

// ===== hw/tcc_pkg.sv
// package: register map, field positions and timing counts of the capture/compare unit
package tcc_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] TCC_ADDR_CTRL_A = 8'h00; // control_reg_a
    localparam logic [7:0] TCC_ADDR_CTRL_B = 8'h04; // control_reg_b
    localparam logic [7:0] TCC_ADDR_CNT_LO = 8'h08; // count_low_byte
    localparam logic [7:0] TCC_ADDR_CNT_HI = 8'h0C; // count_high_byte
    localparam logic [7:0] TCC_ADDR_CMP_A = 8'h10; // compare_reg_a
    localparam logic [7:0] TCC_ADDR_CMP_B = 8'h14; // compare_reg_b
    localparam logic [7:0] TCC_ADDR_FLAGS = 8'h18; // flag register
    localparam logic [7:0] TCC_ADDR_IRQEN = 8'h1C; // interrupt enables
    localparam logic [7:0] TCC_ADDR_SVC = 8'h20; // interrupt serviced strobes
    // control_reg_a fields
    localparam int TCC_CA_WIDTH = 7; // width_select
    localparam int TCC_CA_CAPEN = 6; // capture mode enable
    localparam int TCC_CA_FILT = 5; // noise_filter_enable
    localparam int TCC_CA_EDGE = 4; // capture_edge_select
    localparam int TCC_CA_ACSEL = 3; // comparator_capture_select
    localparam int TCC_CA_WGM = 0; // waveform mode bit
    localparam logic [7:0] TCC_CA_MASK = 8'hF9; // writable bits
    // control_reg_b fields
    localparam int TCC_CB_RUN = 0; // timer tick gate
    // flag / enable bit positions
    localparam int TCC_FL_CMPA = 0; // compare_flag_a
    localparam int TCC_FL_CMPB = 1; // compare_flag_b
    localparam int TCC_FL_CAP = 2; // capture_flag
    localparam int TCC_NFLAG = 3;
    // reset values
    localparam logic [7:0] TCC_RST_BYTE = 8'h00;
    // noise filter length in samples
    localparam int TCC_FILT_SAMPLES = 4;
endpackage

// ===== verification/tcc_capture_compare_checker.sv
// checker: port assertions of the capture/compare unit
module tcc_capture_compare_checker
    import tcc_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic timerTick, // timer tick
    input wire logic captureIrq, // capture request
    input wire logic compareIrqA, // compare a request
    input wire logic compareIrqB // compare b request
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wrDone;
    // a write transfer completing at this edge
    assign wrDone = psel && penable && pready && pwrite;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // bus handshake
    AST_RDY_CAUSE:
        assert property (pready |-> $past(psel && !penable))
        else $error("pready without a setup cycle");
    AST_RDY_ONE: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    AST_ERR_RDY: assert property (pslverr |-> pready)
        else $error("pslverr outside the access phase");
    AST_UNMAPPED:
        assert property (psel && !penable && paddr > TCC_ADDR_SVC |=> pslverr)
        else $error("unmapped address not refused");
    // ==========================================
    // flag requests
    AST_CAP_FALL: assert property ($fell(captureIrq) |-> $past(wrDone))
        else $error("capture request dropped without a write");
    AST_CMPA_FALL:
        assert property ($fell(compareIrqA) |-> $past(wrDone))
        else $error("compare a request dropped without a write");
    AST_CMPA_RISE:
        assert property ($rose(compareIrqA) |-> $past(timerTick || wrDone))
        else $error("compare a request raised off a timer tick");
    AST_CMPB_RISE:
        assert property ($rose(compareIrqB) |-> $past(timerTick || wrDone))
        else $error("compare b request raised off a timer tick");
endmodule

bind tcc_capture_compare tcc_capture_compare_checker chk_u (.clk_sys,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
    .timerTick, .captureIrq, .compareIrqA, .compareIrqB);

// ===== verification/tcc_capture_compare_tb.sv
// self-checking bench of the capture/compare unit
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tcc_capture_compare_tb;
    import tcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, tmo;
    logic [7:0] paddr, cv;
    logic [31:0] pwdata, prdata;
    logic capturePin = 1'b0;
    logic comparatorOut = 1'b0;
    logic timerTick = 1'b0;
    logic captureIrq, compareIrqA, compareIrqB;
    logic [7:0] ctl [6] = '{8'h50, 8'h58, 8'h40, 8'h48, 8'h70, 8'hC0};
    logic [9:0] notes [$];
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 93;
    always #20 clk_sys = ~clk_sys;
    tcc_capture_compare dut_u (.clk_sys, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .capturePin,
        .comparatorOut, .timerTick, .captureIrq, .compareIrqA, .compareIrqB);
    tcc_cpu_model cpu_u (.clk_sys, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .tmo);
    // each completed transfer is matched against the oldest note
    always @(posedge clk_sys) begin
        logic [9:0] nt;
        if (psel && penable && pready === 1'b1) begin
            nt = notes.pop_front();
            `CHK("pslverr", nt[8], pslverr)
            if (nt[9]) `CHK("prdata", nt[7:0], prdata[7:0])
        end
        if (tmo === 1'b1) begin
            n_fail++;
            stop_test();
        end
    end
    // note the expected outcome, then run the transfer
    task automatic op(input bit w, input logic [7:0] a, input logic [7:0] d,
                      input bit e = 1'b0);
        notes.push_back({!w, e, d});
        cpu_u.xfer(w, a, d);
    endtask
    // n single-cycle timer ticks
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            timerTick <= 1'b1;
            @(posedge clk_sys);
            timerTick <= 1'b0;
        end
    endtask
    // counts, verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset value, refused place, 16-bit pairing through one temp
        op(0, TCC_ADDR_CTRL_A, 8'h00);
        op(0, 8'h24, 8'h00, 1'b1);
        op(1, TCC_ADDR_CTRL_A, 8'h80);
        op(1, TCC_ADDR_CNT_HI, 8'h01);
        op(1, TCC_ADDR_CNT_LO, 8'hFF);
        op(0, TCC_ADDR_CNT_LO, 8'hFF);
        op(0, TCC_ADDR_CNT_HI, 8'h01);
        op(1, TCC_ADDR_CMP_B, 8'h56);
        op(1, TCC_ADDR_CMP_A, 8'h78);
        op(1, TCC_ADDR_CNT_LO, 8'h34);
        op(0, TCC_ADDR_CNT_LO, 8'h34);
        op(0, TCC_ADDR_CNT_HI, 8'h56);
        op(0, TCC_ADDR_CMP_A, 8'h78);
        $display("test byte pairing done");
        // every source and edge, the filter, then 16-bit capture
        op(1, TCC_ADDR_IRQEN, 8'h07);
        for (int i = 0; i < 6; i++) begin
            cv = 8'($random(seed));
            op(1, TCC_ADDR_CTRL_A, ctl[i]);
            repeat (10) @(posedge clk_sys);
            op(1, TCC_ADDR_FLAGS, 8'h04);
            op(1, TCC_ADDR_CNT_HI, 8'h0A);
            op(1, TCC_ADDR_CNT_LO, cv);
            if (i == 4) begin
                capturePin <= 1'b1;
                repeat (2) @(posedge clk_sys);
                capturePin <= 1'b0;
                repeat (12) @(posedge clk_sys);
                op(0, TCC_ADDR_FLAGS, 8'h00);
            end
            @(posedge clk_sys);
            if (ctl[i][TCC_CA_ACSEL]) comparatorOut <= ctl[i][TCC_CA_EDGE];
            else capturePin <= ctl[i][TCC_CA_EDGE];
            repeat (12) @(posedge clk_sys);
            `CHK("captureIrq", 1'b1, captureIrq)
            op(0, TCC_ADDR_CMP_A, cv);
            if (i == 5) op(0, TCC_ADDR_CMP_B, 8'h0A);
            op(0, TCC_ADDR_FLAGS, 8'h04);
            op(1, TCC_ADDR_SVC, 8'h04);
            op(0, TCC_ADDR_FLAGS, 8'h00);
        end
        // duty-cycle step: flip the edge after the read, clear, recapture
        op(1, TCC_ADDR_CTRL_A, 8'hD0);
        op(1, TCC_ADDR_FLAGS, 8'h04);
        op(1, TCC_ADDR_CNT_HI, 8'h0B);
        op(1, TCC_ADDR_CNT_LO, ~cv);
        capturePin <= 1'b1;
        repeat (12) @(posedge clk_sys);
        `CHK("captureIrq", 1'b1, captureIrq)
        op(0, TCC_ADDR_CMP_A, ~cv);
        op(0, TCC_ADDR_CMP_B, 8'h0B);
        $display("test capture done");
        // 8-bit matches, a blocked match, then the combined unit
        op(1, TCC_ADDR_CTRL_A, 8'h00);
        op(1, TCC_ADDR_CTRL_B, 8'h01);
        op(1, TCC_ADDR_CMP_A, 8'h05);
        op(1, TCC_ADDR_CMP_B, 8'h06);
        op(1, TCC_ADDR_CNT_LO, 8'h03);
        op(1, TCC_ADDR_FLAGS, 8'h07);
        tick(5);
        op(0, TCC_ADDR_FLAGS, 8'h03);
        `CHK("compareIrqA", 1'b1, compareIrqA)
        `CHK("compareIrqB", 1'b1, compareIrqB)
        op(1, TCC_ADDR_FLAGS, 8'h03);
        op(1, TCC_ADDR_CNT_LO, 8'h05);
        tick(3);
        op(0, TCC_ADDR_FLAGS, 8'h02);
        `CHK("compareIrqA", 1'b0, compareIrqA)
        `CHK("compareIrqB", 1'b1, compareIrqB)
        op(1, TCC_ADDR_CTRL_A, 8'h80);
        op(1, TCC_ADDR_CMP_B, 8'h09);
        op(1, TCC_ADDR_CMP_A, 8'h09);
        op(1, TCC_ADDR_CNT_HI, 8'h09);
        op(1, TCC_ADDR_CNT_LO, 8'h07);
        op(1, TCC_ADDR_FLAGS, 8'h03);
        tick(5);
        op(0, TCC_ADDR_FLAGS, 8'h01);
        `CHK("compareIrqB", 1'b0, compareIrqB)
        op(1, TCC_ADDR_SVC, 8'h01);
        op(0, TCC_ADDR_FLAGS, 8'h00);
        `CHK("compareIrqA", 1'b0, compareIrqA)
        $display("test compare done");
        stop_test();
    end
endmodule

// ===== verification/tcc_cpu_model.sv
// cpu-side apb master model issuing byte register transfers
module tcc_cpu_model (
    input wire logic clk_sys, // system clock
    output logic psel, // apb select
    output logic penable, // apb access phase
    output logic pwrite, // apb direction
    output logic [7:0] paddr, // apb address
    output logic [31:0] pwdata, // apb write data
    input wire logic pready, // apb ready
    output logic tmo // a transfer never completed
);
    timeunit 1ns;
    timeprecision 1ns;
    // bus idle at time zero
    initial {psel, penable, pwrite, paddr, pwdata, tmo} = '0;
    // setup cycle, then access held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 64);
        tmo <= (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
